// file: sim/pcci_host.sv
// pcci_host: host-side AXI4-Lite master model for the command block
// assumes: one clock; the bench calls wr and rd one at a time
`timescale 1ns/1ps
module pcci_host (
   input  wire logic        clk_i,
   output logic [7:0]       awaddr_o,
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output logic             bready_o,
   output logic [7:0]       araddr_o,
   output logic             arvalid_o,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output logic             rready_o
);
   // ************************************************************
   // bus idle at time zero
   // ************************************************************
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end

   // write: both channels offered, each released and scrambled once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_i);
      awaddr_o <= a;
      wdata_o <= d;
      wstrb_o <= 4'hf;
      awvalid_o <= 1'b1;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_i);
         if (awvalid_o && awready_i) begin
            aw_done = 1'b1;
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
         end
         if (wvalid_o && wready_i) begin
            w_done = 1'b1;
            wvalid_o <= 1'b0;
            wdata_o <= ~d;
         end
      end
      do @(posedge clk_i); while (!bvalid_i);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask

   // read: address held until taken, data taken at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do @(posedge clk_i); while (!arready_i);
      arvalid_o <= 1'b0;
      araddr_o <= ~a;
      do @(posedge clk_i); while (!rvalid_i);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask
endmodule

// file: sim/protocol_control_cmd_init_test.sv
// protocol_control_cmd_init_test: command and init sequence bench
// assumes: pcci_ctrl reached through the pcci_host model
`timescale 1ns/1ps
module protocol_control_cmd_init_test;
   logic        ref_clk_i, rst_n_i, awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o;
   logic        bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
   logic [7:0]  awaddr_i, araddr_i;
   logic [31:0] wdata_i, rdata_o, d;
   logic [3:0]  wstrb_i;
   logic [1:0]  bresp_o, rresp_o, r;
   int          fails, n_tests;
   localparam logic [7:0] C = pcci_pkg::ADDR_CMD;
   localparam logic [7:0] E = pcci_pkg::ADDR_EVENT;
   localparam logic [7:0] G = pcci_pkg::ADDR_CFG;
   localparam logic [7:0] K = pcci_pkg::ADDR_KEYS;
   localparam logic [7:0] S = pcci_pkg::ADDR_STATUS;
   typedef struct packed {logic [7:0] a; logic [31:0] v; logic [11:0] e;} pcci_row_t;
   // register write, then status [11:0] expected after it
   pcci_row_t rows [32] = '{
      '{C, 32'h5, 12'h101}, '{G, 32'h1, 12'h101}, '{C, 32'h6, 12'h502},
      '{C, 32'h4, 12'h502}, '{C, 32'h1, 12'h503}, '{C, 32'h7, 12'h100},
      '{C, 32'h5, 12'h101}, '{G, 32'h1f0e, 12'h101}, '{K, 32'h50003, 12'h101},
      '{C, 32'h6, 12'h522}, '{E, 32'h10, 12'h722}, '{C, 32'h1, 12'h762},
      '{C, 32'h3, 12'h722}, '{C, 32'h1, 12'h762}, '{E, 32'h720, 12'h767},
      '{C, 32'h2, 12'h7a7}, '{E, 32'h1, 12'h522}, '{C, 32'h5, 12'h521},
      '{G, 32'h1, 12'h521}, '{C, 32'h6, 12'h502}, '{E, 32'h730, 12'h707},
      '{C, 32'h4, 12'h717}, '{C, 32'h4, 12'h717}, '{E, 32'h1, 12'hf27},
      '{E, 32'h420, 12'hf24}, '{C, 32'h2, 12'hfa4}, '{E, 32'h1, 12'hfa4},
      '{E, 32'h2, 12'hd22}, '{E, 32'h630, 12'hf26}, '{C, 32'h1, 12'hf66},
      '{E, 32'h8, 12'hd23}, '{C, 32'h7, 12'h100}};

   pcci_ctrl dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
      .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
      .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
      .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
      .rready_i(rready_i));
   pcci_host host_u (.clk_i(ref_clk_i), .awaddr_o(awaddr_i), .awvalid_o(awvalid_i),
      .awready_i(awready_o), .wdata_o(wdata_i), .wstrb_o(wstrb_i), .wvalid_o(wvalid_i),
      .wready_i(wready_o), .bresp_i(bresp_o), .bvalid_i(bvalid_o), .bready_o(bready_i),
      .araddr_o(araddr_i), .arvalid_o(arvalid_i), .arready_i(arready_o), .rdata_i(rdata_o),
      .rresp_i(rresp_o), .rvalid_i(rvalid_o), .rready_o(rready_i));

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and stop
   task automatic end_of_test();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // clock
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // hang guard
   initial begin
      #400000;
      fails++;
      end_of_test();
   end

   // main sequence
   initial begin
      rst_n_i = 1'b0;
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      host_u.rd(S, d, r);
      chk({18'h0, d[13:0]}, 32'h100);
      host_u.wr(G, 32'h1f0f, r);
      chk(r, pcci_pkg::RESP_SLVERR);
      host_u.rd(G, d, r);
      chk(d & 32'h1f0e, 32'h0);
      foreach (rows[i]) begin
         host_u.wr(rows[i].a, rows[i].v, r);
         chk(r, pcci_pkg::RESP_OKAY);
         host_u.rd(S, d, r);
         chk(d[11:0], rows[i].e);
      end
      host_u.rd(G, d, r);
      chk(d & 32'h1f0e, 32'h0);
      host_u.rd(K, d, r);
      chk(d & 32'h07ff07ff, 32'h0);
      host_u.rd(S, d, r);
      chk(d[13:10], 4'h0);
      host_u.rd(8'h40, d, r);
      chk(r, pcci_pkg::RESP_SLVERR);
      host_u.rd(pcci_pkg::ADDR_CHAN, d, r);
      chk(d, {30'h0, pcci_pkg::CHAN_RST});
      // mid-run reset from setup with a changed channel set
      host_u.wr(C, {28'h0, pcci_pkg::CMD_SETUP}, r);
      host_u.wr(pcci_pkg::ADDR_CHAN, 32'h1, r);
      chk(r, pcci_pkg::RESP_OKAY);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      host_u.rd(pcci_pkg::ADDR_CHAN, d, r);
      chk(d, {30'h0, pcci_pkg::CHAN_RST});
      host_u.rd(S, d, r);
      chk(d[11:0], 12'h100);
      end_of_test();
   end
endmodule

// file: src/pcci_ctrl.sv
// pcci_ctrl: command capture and initialisation sequence of the
// protocol_operation_control state machine, reached over AXI4-Lite
// assumes: a single master; the core mechanisms report their events
// through the event register and read control back from the status word
`timescale 1ns/1ps

// Contract
// - halt-at-cycle-end accepted in every state except halt.
// - ready-at-cycle-end accepted wherever immediate ready is allowed.
// - with no communication, deferred halt or ready acts at once.
// - with communication, deferred halt or ready waits for cycle end.
// - in wake transmit, act after full pattern or wakeup collision.
// - in collision resolution, act at cycle end or header/CAS receipt.
// - a later deferred halt or ready replaces an earlier one.
// - unserved halt request sets pending halt flag; cycle end enters halt.
// - unserved ready request sets pending ready flag; cycle end enters ready.
// - cancel-pending clears both pending flags at once.
// - enable-all-slots accepted only in normal active or passive.
// - enable-all-slots moves key-slot-only to all-pending, else ignored.
// - all-pending at cycle end permits transmission of all frames.
// - default setup entered at start and from halt on restore, terminating.
// - status initialised before default setup; slot mode key-slot-only.
// - configuration writes only in setup; setup entered from default or ready.
// - setup-done creates, updates status, modes core, enters ready.
// - default setup disables buffers, assigns no slot, clears payload-valid; the code holds no payload-valid bit to clear.
// - default setup leaves no wakeup-in-operation or media test scheduled.
// - other defaults documented; attached channel set kept.
// - entering ready after setup, slot mode follows key-slot-only enable.
// - slot mode has exactly three encodings.
// - coldstart-blocked flag set on every entry to ready.
module pcci_ctrl (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  awaddr_i,
   input  wire logic        awvalid_i,
   output logic             awready_o,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  wstrb_i,
   input  wire logic        wvalid_i,
   output logic             wready_o,
   output logic [1:0]       bresp_o,
   output logic             bvalid_o,
   input  wire logic        bready_i,
   input  wire logic [7:0]  araddr_i,
   input  wire logic        arvalid_i,
   output logic             arready_o,
   output logic [31:0]      rdata_o,
   output logic [1:0]       rresp_o,
   output logic             rvalid_o,
   input  wire logic        rready_i
);

   // ****************************************************************
   // state record
   // ****************************************************************
   typedef struct packed {
      logic                      awr;
      logic                      wr;
      logic [7:0]                aw_addr;
      logic                      aw_have;
      logic [31:0]               w_data;
      logic [3:0]                w_strb;
      logic                      w_have;
      logic                      bv;
      logic [1:0]                bresp;
      logic                      arr;
      logic                      rv;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
      pcci_pkg::pcci_state_t     st;
      pcci_pkg::pcci_slot_mode_t slot_mode;
      logic                      pend_halt;
      logic                      pend_ready;
      logic                      coldstart_blocked;
      logic                      comm_on;
      pcci_pkg::pcci_cfg_t       cfg;
      pcci_pkg::pcci_core_t      core;
   } pcci_ctrl_s_t;

   pcci_ctrl_s_t s_q;
   pcci_ctrl_s_t s_d;

   // immediate ready permitted in these states (wake, startup, collision resolution, normal)
   function automatic logic ready_ok(input pcci_pkg::pcci_state_t st);
      ready_ok = (st == pcci_pkg::ST_WAKE_TX) || (st == pcci_pkg::ST_STARTUP) ||
                 (st == pcci_pkg::ST_COLL_RES) || (st == pcci_pkg::ST_NORM_ACTIVE) ||
                 (st == pcci_pkg::ST_NORM_PASSIVE);
   endfunction

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   logic        wr_fire;
   logic [3:0]  cmd;
   logic [5:0]  ev;
   logic [3:0]  ev_st;
   logic        handle;
   always_comb begin
      s_d     = s_q;
      wr_fire = s_q.aw_have && s_q.w_have && !s_q.bv;
      cmd     = pcci_pkg::CMD_NONE;
      ev      = 6'h00;
      ev_st   = 4'h0;
      handle  = 1'b0;
      s_d.core.terminate = 1'b0;
      s_d.core.create    = 1'b0;
      // address and data channels, taken in either order
      s_d.awr = !s_q.aw_have && !awvalid_i ? 1'b1 : !s_q.aw_have;
      s_d.wr  = !s_q.w_have;
      if (awvalid_i && s_q.awr) begin
         s_d.aw_addr = awaddr_i;
         s_d.aw_have = 1'b1;
         s_d.awr     = 1'b0;
      end
      if (wvalid_i && s_q.wr) begin
         s_d.w_data = wdata_i;
         s_d.w_strb = wstrb_i;
         s_d.w_have = 1'b1;
         s_d.wr     = 1'b0;
      end
      if (s_q.bv && bready_i) begin
         s_d.bv = 1'b0;
      end
      if (wr_fire) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bv      = 1'b1;
         s_d.bresp   = pcci_pkg::RESP_OKAY;
         case (s_q.aw_addr)
            pcci_pkg::ADDR_CMD:   if (s_q.w_strb[0]) cmd = s_q.w_data[3:0];
            pcci_pkg::ADDR_EVENT: begin
               if (s_q.w_strb[0]) ev = s_q.w_data[5:0];
               if (s_q.w_strb[1]) ev_st = s_q.w_data[pcci_pkg::EV_STATE_LSB +: 4];
            end
            pcci_pkg::ADDR_CFG, pcci_pkg::ADDR_KEYS, pcci_pkg::ADDR_CHAN: begin
               if (s_q.st != pcci_pkg::ST_SETUP) begin
                  s_d.bresp = pcci_pkg::RESP_SLVERR;
               end else if (s_q.aw_addr == pcci_pkg::ADDR_CFG) begin
                  s_d.cfg.key_slot_only_enable = s_q.w_data[pcci_pkg::CFG_KSO_BIT];
                  s_d.cfg.key_slot_startup_flag = s_q.w_data[pcci_pkg::CFG_KSU_BIT];
                  s_d.cfg.dual_key_slot_flag = s_q.w_data[pcci_pkg::CFG_DUAL_BIT];
                  s_d.cfg.external_sync_flag = s_q.w_data[pcci_pkg::CFG_EXT_BIT];
                  s_d.cfg.wake_pattern_repetitions =
                     s_q.w_data[pcci_pkg::CFG_WUPR_LSB +: 5];
               end else if (s_q.aw_addr == pcci_pkg::ADDR_KEYS) begin
                  s_d.cfg.first_key_slot_number  = s_q.w_data[10:0];
                  s_d.cfg.second_key_slot_number = s_q.w_data[26:16];
               end else begin
                  s_d.cfg.attached_channel_set = s_q.w_data[1:0];
               end
            end
            pcci_pkg::ADDR_STATUS: ;
            default: s_d.bresp = pcci_pkg::RESP_SLVERR;
         endcase
      end
      // communication-in-progress level from the core
      if (ev[pcci_pkg::EV_COMM_ON]) s_d.comm_on = 1'b1;
      // core reports entry to its wakeup, startup, collision resolution or normal states; a serve wins
      if (ev[pcci_pkg::EV_STATE] && ready_ok(pcci_pkg::pcci_state_t'(ev_st)) &&
          (s_q.st == pcci_pkg::ST_READY || ready_ok(s_q.st))) begin
         s_d.st = pcci_pkg::pcci_state_t'(ev_st);
      end
      // command interpretation
      case (cmd)
         pcci_pkg::CMD_DEF_HALT: begin
            if (s_q.st != pcci_pkg::ST_HALT) begin
               if (!s_q.comm_on) begin
                  s_d.st = pcci_pkg::ST_HALT;
                  s_d.pend_halt  = 1'b0;
                  s_d.pend_ready = 1'b0;
               end else begin
                  s_d.pend_halt  = 1'b1;
                  s_d.pend_ready = 1'b0;
               end
            end
         end
         pcci_pkg::CMD_DEF_READY: begin
            if (ready_ok(s_q.st)) begin
               if (!s_q.comm_on) begin
                  s_d.st = pcci_pkg::ST_READY;
                  s_d.coldstart_blocked = 1'b1;
                  s_d.pend_halt  = 1'b0;
                  s_d.pend_ready = 1'b0;
               end else begin
                  s_d.pend_ready = 1'b1;
                  s_d.pend_halt  = 1'b0;
               end
            end
         end
         pcci_pkg::CMD_CLEAR_DEF: begin
            s_d.pend_halt  = 1'b0;
            s_d.pend_ready = 1'b0;
         end
         pcci_pkg::CMD_ALL_SLOTS: begin
            if ((s_q.st == pcci_pkg::ST_NORM_ACTIVE ||
                 s_q.st == pcci_pkg::ST_NORM_PASSIVE) &&
                s_q.slot_mode == pcci_pkg::SM_KEY_SLOT_ONLY) begin
               s_d.slot_mode = pcci_pkg::SM_ALL_PENDING;
            end
         end
         pcci_pkg::CMD_SETUP: begin
            if (s_q.st == pcci_pkg::ST_DEFAULT_SETUP ||
                s_q.st == pcci_pkg::ST_READY) begin
               s_d.st = pcci_pkg::ST_SETUP;
               s_d.core.terminate = (s_q.st == pcci_pkg::ST_READY);
            end
         end
         pcci_pkg::CMD_SETUP_END: begin
            if (s_q.st == pcci_pkg::ST_SETUP) begin
               s_d.core.create = 1'b1;
               s_d.slot_mode = s_q.cfg.key_slot_only_enable ?
                  pcci_pkg::SM_KEY_SLOT_ONLY : pcci_pkg::SM_ALL;
               s_d.coldstart_blocked = 1'b1;
               s_d.core.buffers_enabled = 1'b1;
               s_d.st = pcci_pkg::ST_READY;
            end
         end
         pcci_pkg::CMD_RESTORE: begin
            if (s_q.st == pcci_pkg::ST_HALT) begin
               s_d.core.terminate = 1'b1;
               s_d.st = pcci_pkg::ST_DEFAULT_SETUP;
               s_d.slot_mode = pcci_pkg::SM_KEY_SLOT_ONLY;
               s_d.pend_halt = 1'b0;
               s_d.pend_ready = 1'b0;
               s_d.comm_on = 1'b0;
               s_d.coldstart_blocked = 1'b1;
               s_d.core.buffers_enabled = 1'b0;
               s_d.core.all_frames_tx = 1'b0;
               s_d.core.wake_during_operation_pattern_sched = 1'b0;
               s_d.core.mts_sched = 1'b0;
               s_d.cfg.first_key_slot_number = pcci_pkg::KEY_SLOT_RST;
               s_d.cfg.second_key_slot_number = pcci_pkg::KEY_SLOT_RST;
               s_d.cfg.key_slot_startup_flag = 1'b0;
               s_d.cfg.dual_key_slot_flag = 1'b0;
               s_d.cfg.external_sync_flag = 1'b0;
               s_d.cfg.wake_pattern_repetitions = pcci_pkg::WUP_REP_RST;
               s_d.cfg.key_slot_only_enable = 1'b0;
            end
         end
         default: ;
      endcase
      // points at which a deferred request is served
      case (s_q.st)
         pcci_pkg::ST_WAKE_TX:
            handle = ev[pcci_pkg::EV_WUP_DONE] || ev[pcci_pkg::EV_WUP_COLL];
         pcci_pkg::ST_COLL_RES:
            handle = ev[pcci_pkg::EV_CYCLE_END] || ev[pcci_pkg::EV_HDR_CAS];
         default:
            handle = ev[pcci_pkg::EV_CYCLE_END];
      endcase
      if (ev[pcci_pkg::EV_CYCLE_END] &&
          s_q.slot_mode == pcci_pkg::SM_ALL_PENDING) begin
         s_d.slot_mode = pcci_pkg::SM_ALL;
         s_d.core.all_frames_tx = 1'b1;
      end
      if (handle && (s_q.pend_halt || s_q.pend_ready) &&
          cmd != pcci_pkg::CMD_CLEAR_DEF) begin
         s_d.st = s_q.pend_halt ? pcci_pkg::ST_HALT : pcci_pkg::ST_READY;
         if (!s_q.pend_halt) s_d.coldstart_blocked = 1'b1;
         s_d.pend_halt  = 1'b0;
         s_d.pend_ready = 1'b0;
         s_d.comm_on    = 1'b0;
      end
      // read channel
      s_d.arr = !s_q.rv && !(arvalid_i && s_q.arr);
      if (s_q.rv && rready_i) s_d.rv = 1'b0;
      if (arvalid_i && s_q.arr) begin
         s_d.rv    = 1'b1;
         s_d.rresp = pcci_pkg::RESP_OKAY;
         case (araddr_i)
            pcci_pkg::ADDR_STATUS: s_d.rdata = {16'h0000,
               s_q.core.create, s_q.core.terminate, s_q.core.mts_sched,
               s_q.core.wake_during_operation_pattern_sched, s_q.core.all_frames_tx, s_q.core.buffers_enabled,
               s_q.comm_on, s_q.coldstart_blocked, s_q.pend_ready, s_q.pend_halt,
               s_q.slot_mode, s_q.st};
            pcci_pkg::ADDR_CFG: s_d.rdata = {19'h00000, s_q.cfg.wake_pattern_repetitions,
               4'h0, s_q.cfg.external_sync_flag, s_q.cfg.dual_key_slot_flag,
               s_q.cfg.key_slot_startup_flag, s_q.cfg.key_slot_only_enable};
            pcci_pkg::ADDR_KEYS: s_d.rdata = {5'h00, s_q.cfg.second_key_slot_number,
               5'h00, s_q.cfg.first_key_slot_number};
            pcci_pkg::ADDR_CHAN: s_d.rdata = {30'h00000000, s_q.cfg.attached_channel_set};
            pcci_pkg::ADDR_CMD, pcci_pkg::ADDR_EVENT: s_d.rdata = 32'h00000000;
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = pcci_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   // ****************************************************************
   // registers; reset enters default setup with initialised status
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s_q       <= '0;
         s_q.awr   <= 1'b1;
         s_q.wr    <= 1'b1;
         s_q.arr   <= 1'b1;
         s_q.st    <= pcci_pkg::ST_DEFAULT_SETUP;
         s_q.slot_mode <= pcci_pkg::SM_KEY_SLOT_ONLY;
         s_q.coldstart_blocked <= 1'b1;
         s_q.cfg.attached_channel_set <= pcci_pkg::CHAN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready_o = s_q.awr;
   assign wready_o  = s_q.wr;
   assign bvalid_o  = s_q.bv;
   assign bresp_o   = s_q.bresp;
   assign arready_o = s_q.arr;
   assign rvalid_o  = s_q.rv;
   assign rdata_o   = s_q.rdata;
   assign rresp_o   = s_q.rresp;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_halt_not_in_halt: assert property (
      s_q.st == pcci_pkg::ST_HALT && cmd == pcci_pkg::CMD_DEF_HALT |=> !s_q.pend_halt)
      else $error("halt request captured in halt");
   a_immediate_halt: assert property (
      cmd == pcci_pkg::CMD_DEF_HALT && !s_q.comm_on && s_q.st != pcci_pkg::ST_HALT
      |=> s_q.st == pcci_pkg::ST_HALT)
      else $error("halt not immediate");
   a_defer_halt: assert property (
      cmd == pcci_pkg::CMD_DEF_HALT && s_q.comm_on && s_q.st != pcci_pkg::ST_HALT
      |=> s_q.pend_halt && !s_q.pend_ready)
      else $error("halt not deferred");
   a_clear_both: assert property (
      cmd == pcci_pkg::CMD_CLEAR_DEF |=> !s_q.pend_halt && !s_q.pend_ready)
      else $error("clear left a flag");
   a_all_slots_gate: assert property (
      cmd == pcci_pkg::CMD_ALL_SLOTS && s_q.st != pcci_pkg::ST_NORM_ACTIVE &&
      s_q.st != pcci_pkg::ST_NORM_PASSIVE |=> s_q.slot_mode == $past(s_q.slot_mode))
      else $error("all slots taken in wrong state");
   a_ready_blocked: assert property (
      s_q.st != pcci_pkg::ST_READY ##1 s_q.st == pcci_pkg::ST_READY |-> s_q.coldstart_blocked)
      else $error("coldstart not blocked on ready");
   a_setup_done_mode: assert property (
      cmd == pcci_pkg::CMD_SETUP_END && s_q.st == pcci_pkg::ST_SETUP && !handle
      |=> s_q.st == pcci_pkg::ST_READY &&
          (s_q.slot_mode == pcci_pkg::SM_KEY_SLOT_ONLY) == s_q.cfg.key_slot_only_enable)
      else $error("slot mode wrong after setup");
   a_served_clears: assert property (
      handle && (s_q.pend_halt || s_q.pend_ready) |=> !s_q.pend_halt && !s_q.pend_ready)
      else $error("pending not cleared");
   a_restore_zero: assert property (
      cmd == pcci_pkg::CMD_RESTORE && s_q.st == pcci_pkg::ST_HALT
      |=> s_q.cfg.first_key_slot_number == 11'h000 && s_q.cfg.wake_pattern_repetitions == 5'h00)
      else $error("defaults not applied");
   // a deferred ready that waits in wake transmit
   sequence s_wake_ready_wait;
      s_q.st == pcci_pkg::ST_WAKE_TX && s_q.pend_ready && !s_q.pend_halt;
   endsequence
   a_wake_hold: assert property (
      s_wake_ready_wait ##0 (cmd == pcci_pkg::CMD_NONE && !ev[pcci_pkg::EV_WUP_DONE] &&
      !ev[pcci_pkg::EV_WUP_COLL] && !ev[pcci_pkg::EV_STATE]) |=> s_q.pend_ready)
      else $error("wake transmit served ready early");
   a_wake_serve: assert property (
      s_wake_ready_wait ##0 ev[pcci_pkg::EV_WUP_DONE] |=> s_q.st == pcci_pkg::ST_READY)
      else $error("wake transmit did not serve ready");
   a_coll_serve: assert property (
      s_q.st == pcci_pkg::ST_COLL_RES && s_q.pend_halt && ev[pcci_pkg::EV_HDR_CAS]
      |=> s_q.st == pcci_pkg::ST_HALT)
      else $error("collision resolution did not serve halt");
   a_all_pending: assert property (
      cmd == pcci_pkg::CMD_ALL_SLOTS && s_q.st == pcci_pkg::ST_NORM_ACTIVE &&
      s_q.slot_mode == pcci_pkg::SM_KEY_SLOT_ONLY
      |=> s_q.slot_mode == pcci_pkg::SM_ALL_PENDING)
      else $error("all slots not captured");
   a_cycle_all: assert property (
      ev[pcci_pkg::EV_CYCLE_END] && s_q.slot_mode == pcci_pkg::SM_ALL_PENDING
      |=> s_q.slot_mode == pcci_pkg::SM_ALL && s_q.core.all_frames_tx)
      else $error("all slots not applied at cycle end");

endmodule

// file: src/pcci_pkg.sv
// pcci_pkg: shared constants, states, register map and carrier structs
// assumes: one 25 MHz clock, AXI4-Lite register access with 32-bit data
package pcci_pkg;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT  = 8'h08;
   localparam logic [7:0] ADDR_CFG    = 8'h0c;
   localparam logic [7:0] ADDR_KEYS   = 8'h10;
   localparam logic [7:0] ADDR_CHAN   = 8'h14;

   // ****************************************************************
   // command codes written to the command register, bits 3:0
   // ****************************************************************
   localparam logic [3:0] CMD_NONE      = 4'h0;
   localparam logic [3:0] CMD_DEF_HALT  = 4'h1;
   localparam logic [3:0] CMD_DEF_READY = 4'h2;
   localparam logic [3:0] CMD_CLEAR_DEF = 4'h3;
   localparam logic [3:0] CMD_ALL_SLOTS = 4'h4;
   localparam logic [3:0] CMD_SETUP     = 4'h5;
   localparam logic [3:0] CMD_SETUP_END = 4'h6;
   localparam logic [3:0] CMD_RESTORE   = 4'h7;

   // ****************************************************************
   // event register bit positions (levels from the core, written as pulses)
   // ****************************************************************
   localparam int EV_CYCLE_END = 0;
   localparam int EV_WUP_DONE  = 1;
   localparam int EV_WUP_COLL  = 2;
   localparam int EV_HDR_CAS   = 3;
   localparam int EV_COMM_ON   = 4;
   localparam int EV_STATE     = 5;   // core reports its procedure state
   localparam int EV_STATE_LSB = 8;   // state code of that report, 4 bits

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int CFG_KSO_BIT   = 0;
   localparam int CFG_KSU_BIT   = 1;
   localparam int CFG_DUAL_BIT  = 2;
   localparam int CFG_EXT_BIT   = 3;
   localparam int CFG_WUPR_LSB  = 8;
   localparam logic [10:0] KEY_SLOT_RST  = 11'h000;
   localparam logic [4:0]  WUP_REP_RST   = 5'h00;
   localparam logic [1:0]  CHAN_RST      = 2'h3;

   // ****************************************************************
   // bus answers
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_DEFAULT_SETUP, ST_SETUP, ST_READY, ST_HALT, ST_WAKE_TX,
      ST_STARTUP, ST_COLL_RES, ST_NORM_ACTIVE, ST_NORM_PASSIVE
   } pcci_state_t;

   typedef enum logic [1:0] {
      SM_KEY_SLOT_ONLY, SM_ALL_PENDING, SM_ALL
   } pcci_slot_mode_t;

   typedef struct packed {
      logic [10:0] first_key_slot_number;
      logic [10:0] second_key_slot_number;
      logic        key_slot_startup_flag;
      logic        dual_key_slot_flag;
      logic [4:0]  wake_pattern_repetitions;
      logic        external_sync_flag;
      logic        key_slot_only_enable;
      logic [1:0]  attached_channel_set;
   } pcci_cfg_t;

   typedef struct packed {
      logic        buffers_enabled;
      logic        all_frames_tx;
      logic        wake_during_operation_pattern_sched;
      logic        mts_sched;
      logic        terminate;
      logic        create;
   } pcci_core_t;

endpackage
